/* File: design/dao_top.sv */
// Output interface of a dual-channel 14-bit sampling converter
// Notes on behaviour
// - Every powered-up channel is sampled on each rising edge of the conversion clock.
// - A channel whose power-down input is high stops converting.
// - A channel whose power-down input is low converts normally.
// - Channel A presents a parallel 14-bit word, bit 0 least significant.
// - Channel B presents a parallel 14-bit word, bit 0 least significant.
// - Output words change only one system clock after the falling edge of the strobe.
// - The strobe toggles at the conversion clock rate, one period a sample.
// - The format select chooses two's complement or offset binary and DCS.
// - Out-of-range inputs saturate to code 16383 or code 0 in offset binary.
`timescale 1ns/10ps
`default_nettype none
module dao_top #(
  parameter int unsigned WIDTH = dao_pkg::RESULT_W,
  parameter int unsigned DEPTH = dao_pkg::FIFO_DEPTH
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_conv_clk,
  input  wire logic [WIDTH-1:0]  i_chan_a_sample,
  input  wire logic              i_chan_a_over,
  input  wire logic              i_chan_a_under,
  input  wire logic [WIDTH-1:0]  i_chan_b_sample,
  input  wire logic              i_chan_b_over,
  input  wire logic              i_chan_b_under,
  input  wire logic              i_chan_a_powerdown,
  input  wire logic              i_chan_b_powerdown,
  input  wire logic [1:0]        i_format_and_duty_select,
  output logic [WIDTH-1:0]       o_chan_a_result_bits,
  output logic [WIDTH-1:0]       o_chan_b_result_bits,
  output logic                   o_output_valid_strobe,
  output logic                   o_chan_a_active,
  output logic                   o_chan_b_active,
  output logic                   o_duty_stab_on,
  output logic                   o_overflow
);
  initial begin
    if (WIDTH != dao_pkg::RESULT_W) begin
      $error("Result width must be 14");
    end
  end

  //****************************************************************
  // Input synchronisers
  //****************************************************************
  logic [4:0]       sy1_ff;
  logic [4:0]       sy2_ff;
  logic [4:0]       nxt_sy1;
  logic [WIDTH-1:0] a_s1_ff;
  logic [WIDTH-1:0] a_s2_ff;
  logic [WIDTH-1:0] b_s1_ff;
  logic [WIDTH-1:0] b_s2_ff;
  logic             clk_d_ff;
  logic             nxt_clk_d;
  logic             clk_rise;
  logic             clk_fall;
  logic             pd_a;
  logic             pd_b;
  logic [1:0]       fmt;

  always_comb begin
    nxt_sy1 = {i_conv_clk, i_chan_a_powerdown, i_chan_b_powerdown,
               i_format_and_duty_select};
    nxt_clk_d = sy2_ff[4];
    clk_rise  = sy2_ff[4] && !clk_d_ff;
    clk_fall  = !sy2_ff[4] && clk_d_ff;
    pd_a      = sy2_ff[3];
    pd_b      = sy2_ff[2];
    fmt       = sy2_ff[1:0];
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sy1_ff   <= '0;
      sy2_ff   <= '0;
      clk_d_ff <= 1'b0;
      a_s1_ff  <= '0;
      a_s2_ff  <= '0;
      b_s1_ff  <= '0;
      b_s2_ff  <= '0;
    end else begin
      sy1_ff   <= nxt_sy1;
      sy2_ff   <= sy1_ff;
      clk_d_ff <= nxt_clk_d;
      a_s1_ff  <= i_chan_a_sample;
      a_s2_ff  <= a_s1_ff;
      b_s1_ff  <= i_chan_b_sample;
      b_s2_ff  <= b_s1_ff;
    end
  end

  // Over/under flags pass the same two stages as the samples
  logic [1:0] ov_s1_ff;
  logic [1:0] ov_s2_ff;
  logic [1:0] un_s1_ff;
  logic [1:0] un_s2_ff;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ov_s1_ff <= '0;
      ov_s2_ff <= '0;
      un_s1_ff <= '0;
      un_s2_ff <= '0;
    end else begin
      ov_s1_ff <= {i_chan_a_over, i_chan_b_over};
      ov_s2_ff <= ov_s1_ff;
      un_s1_ff <= {i_chan_a_under, i_chan_b_under};
      un_s2_ff <= un_s1_ff;
    end
  end

  //****************************************************************
  // Sampling, saturation and format
  //****************************************************************
  function automatic logic [13:0] dao_code(input logic [13:0] raw,
                                           input logic ovr,
                                           input logic und,
                                           input logic [1:0] f);
    logic [13:0] sat;
    sat = ovr ? dao_pkg::CODE_MAX : (und ? dao_pkg::CODE_MIN : raw);
    // Supply and two-thirds levels select two's complement
    if (f == dao_pkg::FMT_SUPPLY || f == dao_pkg::FMT_TWO_THRD) begin
      return sat ^ dao_pkg::MSB_FLIP;
    end
    return sat;
  endfunction

  logic [2*WIDTH-1:0] word_in;
  logic               push;
  logic               in_ready;
  logic               pop_valid;
  logic               pop;
  logic [2*WIDTH-1:0] pop_data;
  logic [WIDTH-1:0]   a_word;
  logic [WIDTH-1:0]   b_word;
  logic               ovf_ff;
  logic               nxt_ovf;

  always_comb begin
    a_word = pd_a ? dao_pkg::RESULT_RST
                  : dao_code(a_s2_ff, ov_s2_ff[1], un_s2_ff[1], fmt);
    b_word = pd_b ? dao_pkg::RESULT_RST
                  : dao_code(b_s2_ff, ov_s2_ff[0], un_s2_ff[0], fmt);
    word_in = {a_word, b_word};
    push    = clk_rise;
    nxt_ovf = ovf_ff || (push && !in_ready);
  end

  dao_fifo #(
    .WIDTH (2 * WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (push),
    .o_in_ready  (in_ready),
    .i_in_data   (word_in),
    .o_out_valid (pop_valid),
    .i_out_ready (pop),
    .o_out_data  (pop_data)
  );

  //****************************************************************
  // Strobe and output words
  //****************************************************************
  dao_pkg::dao_state_type st_ff;
  dao_pkg::dao_state_type nxt_st;
  logic                   strobe_ff;
  logic                   nxt_strobe;
  logic [WIDTH-1:0]       a_out_ff;
  logic [WIDTH-1:0]       b_out_ff;
  logic [WIDTH-1:0]       nxt_a_out;
  logic [WIDTH-1:0]       nxt_b_out;

  always_comb begin
    nxt_st     = st_ff;
    nxt_strobe = strobe_ff;
    nxt_a_out  = a_out_ff;
    nxt_b_out  = b_out_ff;
    pop        = 1'b0;
    // Strobe follows the conversion clock, one period per sample
    if (clk_rise) begin
      nxt_strobe = 1'b1;
    end else if (clk_fall) begin
      nxt_strobe = 1'b0;
    end
    case (st_ff)
      dao_pkg::DAO_ST_IDLE: begin
        if (clk_fall && pop_valid) begin
          nxt_st = dao_pkg::DAO_ST_LOAD;
        end
      end
      dao_pkg::DAO_ST_LOAD: begin
        // Words update one system clock after the strobe falling edge
        pop       = 1'b1;
        nxt_a_out = pop_data[2*WIDTH-1:WIDTH];
        nxt_b_out = pop_data[WIDTH-1:0];
        nxt_st    = dao_pkg::DAO_ST_SHOW;
      end
      dao_pkg::DAO_ST_SHOW: begin
        nxt_st = dao_pkg::DAO_ST_IDLE;
      end
      default: begin
        nxt_st = dao_pkg::DAO_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff     <= dao_pkg::DAO_ST_IDLE;
      strobe_ff <= 1'b0;
      a_out_ff  <= dao_pkg::RESULT_RST;
      b_out_ff  <= dao_pkg::RESULT_RST;
      ovf_ff    <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      strobe_ff <= nxt_strobe;
      a_out_ff  <= nxt_a_out;
      b_out_ff  <= nxt_b_out;
      ovf_ff    <= nxt_ovf;
    end
  end

  always_comb begin
    o_chan_a_result_bits  = a_out_ff;
    o_chan_b_result_bits  = b_out_ff;
    o_output_valid_strobe = strobe_ff;
    o_chan_a_active       = !pd_a;
    o_chan_b_active       = !pd_b;
    o_duty_stab_on        = (fmt == dao_pkg::FMT_TWO_THRD) ||
                            (fmt == dao_pkg::FMT_THIRD);
    o_overflow            = ovf_ff;
  end
endmodule
`default_nettype wire

/* File: design/dao_pkg.sv */
// Shared constants for the dual converter output interface
package dao_pkg;
  localparam int unsigned RESULT_W     = 14;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [13:0] CODE_MAX     = 14'h3fff;
  localparam logic [13:0] CODE_MIN     = 14'h0000;
  localparam logic [13:0] MSB_FLIP     = 14'h2000;
  localparam logic [13:0] RESULT_RST   = 14'h0000;
  // Format select levels after the four-level pin is resolved
  localparam logic [1:0]  FMT_GND      = 2'h0;
  localparam logic [1:0]  FMT_THIRD    = 2'h1;
  localparam logic [1:0]  FMT_TWO_THRD = 2'h2;
  localparam logic [1:0]  FMT_SUPPLY   = 2'h3;
  // Link clock in the bench, ns, and system clock period, ns
  localparam int unsigned SYS_PERIOD_NS = 10;
  localparam int unsigned LINK_PERIOD_NS = 125;
  localparam int unsigned LINK_HALF_CYC =
    (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;
  typedef enum logic [2:0] {
    DAO_ST_IDLE = 3'b001,
    DAO_ST_LOAD = 3'b010,
    DAO_ST_SHOW = 3'b100
  } dao_state_type;
endpackage

/* File: design/dao_fifo.sv */
// Sample FIFO carrying both channel words as one entry
`timescale 1ns/10ps
`default_nettype none
module dao_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("FIFO depth must be a power of two, at least 2");
    end
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic [AW:0]      nxt_wr;
  logic [AW:0]      nxt_rd;
  logic             do_wr;
  logic             do_rd;
  logic             full;
  logic             empty;

  always_comb begin
    empty       = (wr_ff == rd_ff);
    full        = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) &&
                  (wr_ff[AW] != rd_ff[AW]);
    o_in_ready  = !full;
    o_out_valid = !empty;
    do_wr       = i_in_valid && !full;
    do_rd       = i_out_ready && !empty;
    nxt_wr      = do_wr ? wr_ff + 1'b1 : wr_ff;
    nxt_rd      = do_rd ? rd_ff + 1'b1 : rd_ff;
    o_out_data  = mem_ff[rd_ff[AW-1:0]];
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem_ff[wr_ff[AW-1:0]] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

/* File: test/dao_capture_model.sv */
// Capture logic model latching both words on the strobe rise
`timescale 1ns/10ps
`default_nettype none
module dao_capture_model (
  input  wire logic        i_strobe,
  input  wire logic [13:0] i_word_a,
  input  wire logic [13:0] i_word_b,
  output logic [13:0]      o_cap_a,
  output logic [13:0]      o_cap_b,
  output var int           o_cap_cnt
);
  initial o_cap_cnt = 0;
  // Latch away from the falling edge where words move
  always @(posedge i_strobe) begin
    o_cap_a   <= i_word_a;
    o_cap_b   <= i_word_b;
    o_cap_cnt <= o_cap_cnt + 1;
  end
endmodule
`default_nettype wire

/* File: test/dao_top_monitor.sv */
// Concurrent checks on the converter output interface
`timescale 1ns/10ps
`default_nettype none
module dao_top_monitor #(
  parameter int unsigned WIDTH = 14
) (
  input wire logic             i_sys_clk,
  input wire logic             i_rst_b,
  input wire logic             i_conv_clk,
  input wire logic             i_chan_a_powerdown,
  input wire logic             i_chan_b_powerdown,
  input wire logic [1:0]       i_format_and_duty_select,
  input wire logic [WIDTH-1:0] o_chan_a_result_bits,
  input wire logic [WIDTH-1:0] o_chan_b_result_bits,
  input wire logic             o_output_valid_strobe,
  input wire logic             o_chan_a_active,
  input wire logic             o_chan_b_active,
  input wire logic             o_duty_stab_on
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Strobe was high two cycles back and is low now
  sequence s_after_drop;
    !o_output_valid_strobe && $past(o_output_valid_strobe, 2);
  endsequence
  sequence s_a_idle;
    !o_chan_a_active [*8] ##1 $changed(o_chan_a_result_bits);
  endsequence
  strobe_rise_a: assert property (
    $rose(i_conv_clk) |-> ##[1:4] $rose(o_output_valid_strobe))
    else $error("strobe missed a clock rise");
  strobe_fall_a: assert property (
    $fell(i_conv_clk) |-> ##[1:4] $fell(o_output_valid_strobe))
    else $error("strobe missed a clock fall");
  word_a_timing_a: assert property (
    $changed(o_chan_a_result_bits) |-> s_after_drop)
    else $error("word a moved off the strobe fall");
  word_b_timing_a: assert property (
    $changed(o_chan_b_result_bits) |-> s_after_drop)
    else $error("word b moved off the strobe fall");
  pd_zero_a: assert property (
    s_a_idle |-> o_chan_a_result_bits == 14'h0000)
    else $error("powered down word not zero");
  pd_enter_a: assert property (
    $rose(i_chan_a_powerdown) |-> ##[1:3] !o_chan_a_active)
    else $error("channel a stayed active");
  pd_leave_a: assert property (
    $fell(i_chan_b_powerdown) |-> ##[1:3] o_chan_b_active)
    else $error("channel b stayed down");
  dcs_select_a: assert property (
    $stable(i_format_and_duty_select) [*6] |-> o_duty_stab_on ==
    (i_format_and_duty_select inside {2'h1, 2'h2}))
    else $error("duty stabilizer select wrong");
endmodule
bind dao_top dao_top_monitor #(.WIDTH(WIDTH)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_conv_clk(i_conv_clk),
  .i_chan_a_powerdown(i_chan_a_powerdown),
  .i_chan_b_powerdown(i_chan_b_powerdown),
  .i_format_and_duty_select(i_format_and_duty_select),
  .o_chan_a_result_bits(o_chan_a_result_bits),
  .o_chan_b_result_bits(o_chan_b_result_bits),
  .o_output_valid_strobe(o_output_valid_strobe),
  .o_chan_a_active(o_chan_a_active), .o_chan_b_active(o_chan_b_active),
  .o_duty_stab_on(o_duty_stab_on));
`default_nettype wire

/* File: test/test_dao_top.sv */
// Self-checking bench for the converter output interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); \
  end \
end
module test_dao_top;
  logic        clk, rst_b, cclk, oa, ua, ob, ub, pa, pb, stb, aa, ab, dcs, ovf;
  logic [13:0] sa, sb, wa, wb, ca, cb;
  logic [1:0]  fmt;
  int          cnt, failures, total_checks;
  dao_top DUT (.i_sys_clk(clk), .i_rst_b(rst_b), .i_conv_clk(cclk),
    .i_chan_a_sample(sa), .i_chan_a_over(oa), .i_chan_a_under(ua),
    .i_chan_b_sample(sb), .i_chan_b_over(ob), .i_chan_b_under(ub),
    .i_chan_a_powerdown(pa), .i_chan_b_powerdown(pb),
    .i_format_and_duty_select(fmt), .o_chan_a_result_bits(wa),
    .o_chan_b_result_bits(wb), .o_output_valid_strobe(stb),
    .o_chan_a_active(aa), .o_chan_b_active(ab), .o_duty_stab_on(dcs),
    .o_overflow(ovf));
  dao_capture_model u_cap (.i_strobe(stb), .i_word_a(wa), .i_word_b(wb),
    .o_cap_a(ca), .o_cap_b(cb), .o_cap_cnt(cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cclk = 1'b0;
    #3;
    forever #62.5 cclk = ~cclk;
  end
  function automatic logic [13:0] exp_word(logic [13:0] s, logic ov,
                                           logic un, logic [1:0] f, logic pd);
    logic [13:0] w;
    w = ov ? dao_pkg::CODE_MAX : (un ? dao_pkg::CODE_MIN : s);
    if (f[1]) w = w ^ dao_pkg::MSB_FLIP;
    return pd ? 14'h0000 : w;
  endfunction
  task automatic apply(input logic [13:0] xa, xb, input logic [3:0] fl,
                       input logic [1:0] f, input logic xpa, xpb);
    @(posedge clk);
    sa <= xa;
    sb <= xb;
    {oa, ua, ob, ub} <= fl;
    fmt <= f;
    pa <= xpa;
    pb <= xpb;
    repeat (3) @(posedge stb);
    #1;
    `CHK("word_a", exp_word(xa, fl[3], fl[2], f, xpa), ca)
    `CHK("word_b", exp_word(xb, fl[1], fl[0], f, xpb), cb)
  endtask
  task automatic t_formats;
    for (int f = 0; f < 4; f++) begin
      apply(14'h2c35, 14'h0a5b, 4'h0, f[1:0], 1'b0, 1'b0);
      `CHK("dcs", (f == 1 || f == 2), dcs)
    end
  endtask
  task automatic t_saturate;
    apply(14'h1111, 14'h3ffe, 4'h9, dao_pkg::FMT_GND, 1'b0, 1'b0);
    apply(14'h0001, 14'h2222, 4'he, dao_pkg::FMT_SUPPLY, 1'b0, 1'b0);
  endtask
  task automatic t_powerdown;
    apply(14'h1abc, 14'h0123, 4'h0, dao_pkg::FMT_THIRD, 1'b1, 1'b0);
    `CHK("act_a", 1'b0, aa)
    apply(14'h0456, 14'h3210, 4'h0, dao_pkg::FMT_GND, 1'b0, 1'b1);
    `CHK("act_b", 1'b0, ab)
    `CHK("act_a", 1'b1, aa)
    apply(14'h0457, 14'h3211, 4'h0, dao_pkg::FMT_GND, 1'b0, 1'b0);
  endtask
  task automatic t_rate;
    int n;
    n = cnt;
    repeat (1000) @(posedge clk);
    `CHK("rate", 1'b1, (cnt - n >= 79 && cnt - n <= 81))
    `CHK("overflow", 1'b0, ovf)
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #60us;
    failures++;
    results;
  end
  initial begin
    {rst_b, oa, ua, ob, ub, pa, pb, fmt, sa, sb} = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("reset_word", 14'h0000, wa)
    t_formats;
    t_saturate;
    t_powerdown;
    t_rate;
    results;
  end
endmodule
`default_nettype wire
